// file: host_irq_gate.sv
// Overview of operation
// - Main enable bit one lets its event bit drive the interrupt; zero blocks it.
// - Ones at enable-set address set enable bits; ones at enable-clear clear them.
// - Enable bits match event positions; 9-15, 18, 27-29 reserved; 31 global.
// - Global enable bit 31 at zero blocks every processor interrupt.
// - Event-clear read returns events AND enables regardless of global enable.
// - Reset clears global enable bit 31 and all other main enable bits.
// - Context pending and enable registers are 32 bits with set/clear addresses.
// - Zero bits written to context set or clear addresses change nothing.
// - Transmit pending bit set when final descriptor completes with interrupt-always.
// - Nonzero transmit pending AND enable makes transmit summary read one.
// - Nonzero receive pending AND enable makes receive summary read one.
// - Software pending-set write raises interrupts like a hardware completion.
// - Pending-set read gives raw bits; pending-clear read gives masked bits.
// - Enable bits of unimplemented contexts always read zero.
// - Context pending and enable bits need no particular reset value.
// - Each receive pending bit stands for one receive context completion.
// - Transmit summary at bit 6 is combinational OR of pending AND enable.
// - Receive summary at bit 7 is combinational OR of pending AND enable.
module host_irq_gate #(
  parameter int TX_CONTEXTS = 4,
  parameter int RX_CONTEXTS = 4
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic soft_reset, // Soft reset pulse, active high.
  input wire irq_gate_pkg::reg_req_t bus_req, // Register request.
  output logic [31:0] bus_rdata, // Read data, one cycle after the read strobe.
  input wire logic [31:0] main_pending_events, // Latched main events from outside.
  input wire irq_gate_pkg::ctx_done_t ctx_done, // One-cycle completion pulses per context.
  input wire logic [31:0] tx_done_irq_bits, // Bit pairs unused; see ctx_irq_code.
  input wire logic [1:0] ctx_irq_code, // Interrupt-request field of the completing descriptor.
  output logic irq // Processor interrupt, level.
);
  initial begin
    if (TX_CONTEXTS < 1 || TX_CONTEXTS > 32 || RX_CONTEXTS < 1 || RX_CONTEXTS > 32) begin
      $error("Context counts must lie in 1..32.");
    end
  end

  localparam logic [31:0] TX_IMPL = 32'hFFFFFFFF >> (32 - TX_CONTEXTS);
  localparam logic [31:0] RX_IMPL = 32'hFFFFFFFF >> (32 - RX_CONTEXTS);

  logic [31:0] main_irq_enable;
  logic [31:0] tx_context_pending;
  logic [31:0] tx_context_enable;
  logic [31:0] rx_context_pending;
  logic [31:0] rx_context_enable;
  logic tx_context_summary;
  logic rx_context_summary;
  logic [31:0] main_events;
  logic [31:0] main_masked;
  logic tx_hw_set_en;

  function automatic logic wr_at(irq_gate_pkg::reg_req_t r, logic [5:0] ofs);
    wr_at = r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [31:0] set_clr(logic [31:0] cur, logic [31:0] set_bits,
                                          logic [31:0] clr_bits, logic [31:0] impl);
    // Hardware and software sets win over a clear in the same cycle.
    set_clr = ((cur & ~clr_bits) | set_bits) & impl;
  endfunction

  assign tx_context_summary = |(tx_context_pending & tx_context_enable);
  assign rx_context_summary = |(rx_context_pending & rx_context_enable);

  always_comb begin
    main_events = main_pending_events & irq_gate_pkg::MAIN_EVENT_EXT;
    main_events[irq_gate_pkg::BIT_TX_SUMMARY] = tx_context_summary;
    main_events[irq_gate_pkg::BIT_RX_SUMMARY] = rx_context_summary;
  end

  assign main_masked = main_events & main_irq_enable
    & ~(32'h00000001 << irq_gate_pkg::BIT_GLOBAL);

  assign irq = main_irq_enable[irq_gate_pkg::BIT_GLOBAL] && (|main_masked);

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      main_irq_enable <= irq_gate_pkg::WORD_ZERO;
    end else begin
      main_irq_enable <= set_clr(main_irq_enable,
        wr_at(bus_req, irq_gate_pkg::OFS_ENABLE_SET) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        wr_at(bus_req, irq_gate_pkg::OFS_ENABLE_CLEAR) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        irq_gate_pkg::MAIN_ENABLE_IMPL);
    end
  end

  assign tx_hw_set_en = (ctx_irq_code == irq_gate_pkg::IRQ_ALWAYS);

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      tx_context_pending <= irq_gate_pkg::WORD_ZERO;
    end else begin
      tx_context_pending <= set_clr(tx_context_pending,
        (wr_at(bus_req, irq_gate_pkg::OFS_TX_PEND_SET) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO)
        | (tx_hw_set_en ? ctx_done.tx_done : irq_gate_pkg::WORD_ZERO),
        wr_at(bus_req, irq_gate_pkg::OFS_TX_PEND_CLEAR) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        TX_IMPL);
    end
  end

  // Receive pending, one bit per context.
  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      rx_context_pending <= irq_gate_pkg::WORD_ZERO;
    end else begin
      rx_context_pending <= set_clr(rx_context_pending,
        (wr_at(bus_req, irq_gate_pkg::OFS_RX_PEND_SET) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO)
        | (tx_hw_set_en ? ctx_done.rx_done : irq_gate_pkg::WORD_ZERO),
        wr_at(bus_req, irq_gate_pkg::OFS_RX_PEND_CLEAR) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        RX_IMPL);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset) begin
      tx_context_enable <= irq_gate_pkg::WORD_ZERO;
      rx_context_enable <= irq_gate_pkg::WORD_ZERO;
    end else begin
      tx_context_enable <= set_clr(tx_context_enable,
        wr_at(bus_req, irq_gate_pkg::OFS_TX_EN_SET) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        wr_at(bus_req, irq_gate_pkg::OFS_TX_EN_CLEAR) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        TX_IMPL);
      rx_context_enable <= set_clr(rx_context_enable,
        wr_at(bus_req, irq_gate_pkg::OFS_RX_EN_SET) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        wr_at(bus_req, irq_gate_pkg::OFS_RX_EN_CLEAR) ? bus_req.wdata : irq_gate_pkg::WORD_ZERO,
        RX_IMPL);
    end
  end

  // Read data is registered; unmapped addresses and idle cycles return zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= irq_gate_pkg::WORD_ZERO;
    end else if (!bus_req.rd) begin
      bus_rdata <= irq_gate_pkg::WORD_ZERO;
    end else begin
      case (bus_req.addr)
        irq_gate_pkg::OFS_EVENT_SET: bus_rdata <= main_events;
        irq_gate_pkg::OFS_EVENT_CLEAR: bus_rdata <= main_masked;
        irq_gate_pkg::OFS_ENABLE_SET,
        irq_gate_pkg::OFS_ENABLE_CLEAR: bus_rdata <= main_irq_enable;
        irq_gate_pkg::OFS_TX_PEND_SET: bus_rdata <= tx_context_pending;
        irq_gate_pkg::OFS_TX_PEND_CLEAR: bus_rdata <= tx_context_pending & tx_context_enable;
        irq_gate_pkg::OFS_TX_EN_SET,
        irq_gate_pkg::OFS_TX_EN_CLEAR: bus_rdata <= tx_context_enable;
        irq_gate_pkg::OFS_RX_PEND_SET: bus_rdata <= rx_context_pending;
        irq_gate_pkg::OFS_RX_PEND_CLEAR: bus_rdata <= rx_context_pending & rx_context_enable;
        irq_gate_pkg::OFS_RX_EN_SET,
        irq_gate_pkg::OFS_RX_EN_CLEAR: bus_rdata <= rx_context_enable;
        default: bus_rdata <= irq_gate_pkg::WORD_ZERO;
      endcase
    end
  end
endmodule // host_irq_gate

// file: irq_gate_pkg.sv
package irq_gate_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses, one aligned word each).
  localparam logic [5:0] OFS_EVENT_SET = 6'h00;
  localparam logic [5:0] OFS_EVENT_CLEAR = 6'h04;
  localparam logic [5:0] OFS_ENABLE_SET = 6'h08;
  localparam logic [5:0] OFS_ENABLE_CLEAR = 6'h0C;
  localparam logic [5:0] OFS_TX_PEND_SET = 6'h10;
  localparam logic [5:0] OFS_TX_PEND_CLEAR = 6'h14;
  localparam logic [5:0] OFS_TX_EN_SET = 6'h18;
  localparam logic [5:0] OFS_TX_EN_CLEAR = 6'h1C;
  localparam logic [5:0] OFS_RX_PEND_SET = 6'h20;
  localparam logic [5:0] OFS_RX_PEND_CLEAR = 6'h24;
  localparam logic [5:0] OFS_RX_EN_SET = 6'h28;
  localparam logic [5:0] OFS_RX_EN_CLEAR = 6'h2C;

  // Main event bit positions.
  localparam int BIT_TX_SUMMARY = 6;
  localparam int BIT_RX_SUMMARY = 7;
  localparam int BIT_GLOBAL = 31;

  // Implemented main enable bits: 0-8, 16-17, 19-26, 30 and the global gate 31.
  localparam logic [31:0] MAIN_ENABLE_IMPL = 32'hC7FB01FF;
  // Event bits driven from outside this block (summaries 6, 7 are built here).
  localparam logic [31:0] MAIN_EVENT_EXT = 32'h47FB013F;

  localparam logic [1:0] IRQ_ALWAYS = 2'h3;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [31:0] tx_done;
    logic [31:0] rx_done;
  } ctx_done_t;
endpackage

// file: host_irq_gate_checker.sv
module host_irq_gate_checker #(
  parameter int TX_CONTEXTS = 4,
  parameter int RX_CONTEXTS = 4
) (
  input wire logic clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic soft_reset, // Soft reset.
  input wire irq_gate_pkg::reg_req_t bus_req, // Register request.
  input wire logic [31:0] bus_rdata, // Read data.
  input wire logic [31:0] main_pending_events, // Main events.
  input wire irq_gate_pkg::ctx_done_t ctx_done, // Completions.
  input wire logic [31:0] tx_done_irq_bits, // Unused input.
  input wire logic [1:0] ctx_irq_code, // Descriptor field.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [5:0] a = bus_req.addr;
  wire logic calm = ctx_done == 0 && !soft_reset;
  property p_rst_low; $rose(resetn) |-> !irq; endproperty
  a_rst_low: assert property (p_rst_low) else $error("irq high after reset");
  property p_soft_low; soft_reset |=> !irq; endproperty
  a_soft_low: assert property (p_soft_low) else $error("irq high after soft reset");
  property p_gate_off; bus_req.wr && a == irq_gate_pkg::OFS_ENABLE_CLEAR && bus_req.wdata[31] |=> !irq; endproperty
  a_gate_off: assert property (p_gate_off) else $error("irq with global gate off");
  property p_tx_impl; bus_req.rd && a == irq_gate_pkg::OFS_TX_EN_SET |=> (bus_rdata >> TX_CONTEXTS) == 0; endproperty
  a_tx_impl: assert property (p_tx_impl) else $error("absent tx context enabled");
  property p_rx_impl; bus_req.rd && a == irq_gate_pkg::OFS_RX_EN_SET |=> (bus_rdata >> RX_CONTEXTS) == 0; endproperty
  a_rx_impl: assert property (p_rx_impl) else $error("absent rx context enabled");
  property p_mask_rsv; bus_req.rd && a == irq_gate_pkg::OFS_EVENT_CLEAR |=> (bus_rdata & ~irq_gate_pkg::MAIN_ENABLE_IMPL) == 0; endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("reserved bit in masked read");
  property p_cause; !$stable(irq) |-> !$past(resetn) || $past(bus_req.wr) || $past(soft_reset) || $past(ctx_done) != 0 || !$stable(main_pending_events); endproperty
  a_cause: assert property (p_cause) else $error("irq moved without cause");
  property p_zero_wr; bus_req.wr && bus_req.wdata == 0 && a >= 6'h10 && calm |=> $stable(irq) || !$stable(main_pending_events); endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write changed irq");
  property p_code; ctx_done != 0 && ctx_irq_code != irq_gate_pkg::IRQ_ALWAYS && !bus_req.wr && !soft_reset |=> $stable(irq) || !$stable(main_pending_events); endproperty
  a_code: assert property (p_code) else $error("completion without always code raised irq");
  c_irq: cover property ($rose(irq));
  c_masked: cover property (bus_req.rd && a == irq_gate_pkg::OFS_EVENT_CLEAR ##1 bus_rdata != 0);
  c_soft: cover property (soft_reset ##1 !irq);
endmodule // host_irq_gate_checker

bind host_irq_gate host_irq_gate_checker #(.TX_CONTEXTS(TX_CONTEXTS), .RX_CONTEXTS(RX_CONTEXTS))
  host_irq_gate_checker_inst (.clk(clk), .resetn(resetn), .soft_reset(soft_reset),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .main_pending_events(main_pending_events),
  .ctx_done(ctx_done), .tx_done_irq_bits(tx_done_irq_bits), .ctx_irq_code(ctx_irq_code), .irq(irq));

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NT = 3;
  localparam int NR = 5;
  logic clk = 0;
  logic resetn = 0;
  logic soft_reset = 0;
  irq_gate_pkg::reg_req_t req = '0;
  logic [63:0] done = '0;
  logic [31:0] mev = '0;
  logic [1:0] code = '0;
  logic [31:0] bus_rdata;
  logic irq;
  logic [31:0] p, r, m;
  logic [5:0] b;
  int error_cnt = 0;
  int total_checks = 0;
  host_irq_gate #(.TX_CONTEXTS(NT), .RX_CONTEXTS(NR)) host_irq_gate_inst (.clk(clk),
    .resetn(resetn), .soft_reset(soft_reset), .bus_req(req), .bus_rdata(bus_rdata),
    .main_pending_events(mev), .ctx_done(done), .tx_done_irq_bits(32'h00000000),
    .ctx_irq_code(code), .irq(irq));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] impl(int n);
    return (n == 32) ? 32'hFFFFFFFF : (32'h00000001 << n) - 32'h00000001;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] exp);
    req <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk("rdata", bus_rdata, exp);
    @(posedge clk);
  endtask
  task automatic ci(logic e);
    #1 chk("irq", {31'h00000000, irq}, {31'h00000000, e});
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h7DE8));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    mev <= 32'hFFFFFFFF;
    @(posedge clk);
    ci(1'b0);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      b = 6'h10 + 6'(k * 16);
      m = impl(k ? NR : NT);
      mev <= 32'h00000000;
      p = $urandom;
      r = $urandom;
      wr(b + 6'h08, 32'hFFFFFFFF);
      rd(b + 6'h08, m);
      wr(b, p);
      wr(b + 6'h0C, r);
      wr(b, 32'h00000000);
      wr(b + 6'h04, 32'h00000000);
      rd(b, p & m);
      rd(b + 6'h04, p & ~r & m);
      wr(irq_gate_pkg::OFS_ENABLE_SET, 32'h80000000 | (32'h00000040 << k));
      ci(|(p & ~r & m));
      wr(irq_gate_pkg::OFS_ENABLE_CLEAR, 32'h80000000);
      ci(1'b0);
      rd(irq_gate_pkg::OFS_EVENT_CLEAR, (|(p & ~r & m)) ? (32'h00000040 << k) : 32'h00000000);
      wr(b + 6'h04, 32'hFFFFFFFF);
      wr(b + 6'h08, 32'h00000001);
      wr(irq_gate_pkg::OFS_ENABLE_SET, 32'h80000000);
      for (int c = 0; c < 4; c++) begin
        code <= 2'(c);
        done <= 64'h0000000000000001 << (k ? 0 : 32);
        @(posedge clk);
        done <= '0;
        @(posedge clk);
        ci(c == 3);
        wr(b + 6'h04, 32'h00000001);
      end
      wr(irq_gate_pkg::OFS_ENABLE_CLEAR, 32'hFFFFFFFF);
      $display("test context %0d done", k);
    end
    p = $urandom | 32'h00000001;
    mev <= p;
    wr(irq_gate_pkg::OFS_ENABLE_SET, 32'hFFFFFFFF);
    ci(1'b1);
    rd(irq_gate_pkg::OFS_EVENT_CLEAR, p & irq_gate_pkg::MAIN_EVENT_EXT);
    wr(irq_gate_pkg::OFS_ENABLE_CLEAR, p);
    ci(1'b0);
    rd(6'h30, 32'h00000000);
    $display("test main done");
    wr(irq_gate_pkg::OFS_ENABLE_SET, 32'hFFFFFFFF);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(posedge clk);
    ci(1'b0);
    $display("test soft done");
    test_done();
  end
endmodule // tb
